//--- drx_pkg.sv
// Constants, types and helpers shared by the receive DMA interrupt status/mask block.
// Assumes one 40 MHz core clock and an APB master with 32-bit data.
`default_nettype none

package drx_pkg;

	localparam int NUM_CH   = 8;
	localparam int ADDR_W   = 8;
	localparam int DATA_W   = 32;
	localparam int FLAG_W   = 16;
	localparam int LIMIT_W  = 8;
	localparam int COUNT_W  = 16;
	localparam int USED_W   = 8;
	localparam int DMA_W    = 2;
	localparam int EVT_W    = 18;
	localparam int STAT_NUM = 4;

	localparam int FRAME_LSB  = 0;
	localparam int THRESH_LSB = 8;
	localparam int HOST_BIT   = 1;
	localparam int STAT_BIT   = 0;

	localparam logic [ADDR_W-1:0] OFS_RX_RAW     = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_RX_MASKED  = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_RX_SET     = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_RX_CLEAR   = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_DMA_RAW    = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_DMA_MASKED = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_DMA_ENABLE = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 8'h1c;
	localparam logic [ADDR_W-1:0] OFS_EVT_MASK   = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_LIMIT_BASE = 8'h40;
	localparam logic [ADDR_W-1:0] OFS_COUNT_BASE = 8'h60;

	localparam logic [FLAG_W-1:0]  RST_RX_ENABLE = 16'h0000;
	localparam logic [DMA_W-1:0]   RST_DMA_EN    = 2'h0;
	localparam logic [EVT_W-1:0]   RST_EVT       = 18'h00000;
	localparam logic [LIMIT_W-1:0] RST_LIMIT     = 8'h00;
	localparam logic [COUNT_W-1:0] RST_COUNT     = 16'h0000;

	typedef enum logic [1:0] {
		APB_IDLE = 2'b00,
		APB_HELD = 2'b01
	} drx_apb_state_t;

	// Per-channel banks are eight consecutive words
	function automatic logic drx_in_bank(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] base);
		return (addr[7:5] == base[7:5]) && (addr[1:0] == 2'b00);
	endfunction

	function automatic logic [2:0] drx_bank_index(input logic [ADDR_W-1:0] addr);
		return addr[4:2];
	endfunction

endpackage : drx_pkg

`default_nettype wire

//--- drx_apb_port.sv
// APB slave front end: zero-wait access phase, read data captured in the setup cycle.
// Assumes the master holds address and data from setup until pready is seen.
`default_nettype none

module drx_apb_port
	import drx_pkg::*;
(
	input  wire logic                      i_core_clk,
	input  wire logic                      i_rst,
	input  wire logic                      i_clk_en,
	input  wire logic                      i_psel,
	input  wire logic                      i_penable,
	input  wire logic                      i_pwrite,
	input  wire logic [drx_pkg::DATA_W-1:0] i_pwdata,
	input  wire logic [3:0]                i_pstrb,
	input  wire logic [drx_pkg::DATA_W-1:0] i_rd_data,
	input  wire logic                      i_addr_ok,
	output logic                           o_pready,
	output logic      [drx_pkg::DATA_W-1:0] o_prdata,
	output logic                           o_pslverr,
	output logic                           o_wr_stb,
	output logic      [drx_pkg::DATA_W-1:0] o_wr_data
);
	import drx_pkg::*;

	drx_apb_state_t            state_r;
	drx_apb_state_t            state_nxt;
	logic                      err_r;
	logic      [DATA_W-1:0]    lane_mask;

	wire setup_seen = i_psel & ~i_penable;

	assign lane_mask = {{8{i_pstrb[3]}}, {8{i_pstrb[2]}}, {8{i_pstrb[1]}}, {8{i_pstrb[0]}}};
	assign o_pready  = (state_r == APB_HELD) & i_psel & i_penable & i_clk_en;
	assign o_pslverr = o_pready & err_r;
	// Unmapped writes are dropped here so no register ever sees them
	assign o_wr_stb  = o_pready & i_pwrite & ~err_r;
	assign o_wr_data = i_pwdata & lane_mask;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			APB_IDLE: state_nxt = setup_seen ? APB_HELD : APB_IDLE;
			APB_HELD: state_nxt = o_pready ? APB_IDLE : APB_HELD;
			default:  state_nxt = APB_IDLE;
		endcase
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			state_r  <= APB_IDLE;
			err_r    <= 1'b0;
			o_prdata <= '0;
		end else if (i_clk_en) begin
			state_r <= state_nxt;
			if (setup_seen) begin
				err_r    <= ~i_addr_ok;
				o_prdata <= i_pwrite ? '0 : (i_addr_ok ? i_rd_data : '0);
			end
		end
	end

	sequence s_setup;
		i_psel && !i_penable && i_clk_en;
	endsequence

	sequence s_access;
		i_psel && i_penable && i_clk_en;
	endsequence

	chk_ready_no_wait: assert property (@(posedge i_core_clk) disable iff (i_rst)
		s_setup ##1 s_access |-> o_pready)
		else $error("access phase after setup did not complete at once");

endmodule : drx_apb_port

`default_nettype wire

//--- drx_chan_thresh.sv
// One receive channel's spare-buffer counter, its limit and the low-buffer flag.
// Assumes used-buffer reports come as one-cycle pulses from the receive engine.
`default_nettype none

module drx_chan_thresh
	import drx_pkg::*;
(
	input  wire logic                        i_core_clk,
	input  wire logic                        i_rst,
	input  wire logic                        i_clk_en,
	input  wire logic                        i_limit_wr,
	input  wire logic                        i_count_wr,
	input  wire logic [drx_pkg::DATA_W-1:0]  i_wr_data,
	input  wire logic                        i_used_vld,
	input  wire logic [drx_pkg::USED_W-1:0]  i_used_cnt,
	output logic      [drx_pkg::LIMIT_W-1:0] o_limit,
	output logic      [drx_pkg::COUNT_W-1:0] o_count,
	output logic                             o_low_flag
);
	import drx_pkg::*;

	logic [COUNT_W-1:0] add_term;
	logic [COUNT_W-1:0] sub_term;
	logic [COUNT_W-1:0] count_nxt;

	// Writes add rather than load, so the counter wraps around modulo 2^16 on overflow
	assign add_term  = i_count_wr ? i_wr_data[COUNT_W-1:0] : '0;
	assign sub_term  = i_used_vld ? {{(COUNT_W-USED_W){1'b0}}, i_used_cnt} : '0;
	assign count_nxt = o_count + add_term - sub_term;

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_limit    <= RST_LIMIT;
			o_count    <= RST_COUNT;
			o_low_flag <= 1'b0;
		end else if (i_clk_en) begin
			if (i_limit_wr) begin
				o_limit <= i_wr_data[LIMIT_W-1:0];
			end
			o_count    <= count_nxt;
			o_low_flag <= o_count < {{(COUNT_W-LIMIT_W){1'b0}}, o_limit};
		end
	end

	chk_low_compare: assert property (@(posedge i_core_clk) disable iff (i_rst)
		i_clk_en |=> o_low_flag == ($past(o_count) < {8'h00, $past(o_limit)}))
		else $error("low-buffer flag does not follow count against limit");

endmodule : drx_chan_thresh

`default_nettype wire

//--- drx_irq_top.sv
// Receive DMA interrupt status and enable registers with APB access.
// Assumes frame-done, host-fault and counter tops are synchronous levels from the DMA engine.
//
// The register offsets and the APB register port were left to the implementer.
`default_nettype none

module drx_irq_top
	import drx_pkg::*;
(
	input  wire logic                                    i_core_clk,
	input  wire logic                                    i_rst,
	input  wire logic                                    i_clk_en,
	input  wire logic                                    i_psel,
	input  wire logic                                    i_penable,
	input  wire logic                                    i_pwrite,
	input  wire logic [drx_pkg::ADDR_W-1:0]              i_paddr,
	input  wire logic [drx_pkg::DATA_W-1:0]              i_pwdata,
	input  wire logic [3:0]                              i_pstrb,
	output logic                                         o_pready,
	output logic      [drx_pkg::DATA_W-1:0]              o_prdata,
	output logic                                         o_pslverr,
	input  wire logic [drx_pkg::NUM_CH-1:0]              i_rx_frame_done,
	input  wire logic [drx_pkg::NUM_CH-1:0]              i_rx_used_vld,
	input  wire logic [drx_pkg::NUM_CH-1:0][drx_pkg::USED_W-1:0] i_rx_used_cnt,
	input  wire logic                                    i_host_fault,
	input  wire logic [drx_pkg::STAT_NUM-1:0]            i_stat_counter_top,
	output logic                                         o_rx_irq,
	output logic                                         o_dma_irq,
	output logic                                         o_irq
);
	import drx_pkg::*;

	logic [NUM_CH-1:0]  rx_frame_done_flag_r;
	logic               host_fault_flag_r;
	logic               counter_half_flag_r;
	logic [FLAG_W-1:0]  rx_enable_r;
	logic [FLAG_W-1:0]  rx_enable_nxt;
	logic [DMA_W-1:0]   dma_enable_r;
	logic [EVT_W-1:0]   evt_prev_r;
	logic [EVT_W-1:0]   evt_status_r;
	logic [EVT_W-1:0]   evt_status_nxt;
	logic [EVT_W-1:0]   evt_mask_r;

	logic [NUM_CH-1:0]  rx_low_buffer_flag;
	logic [LIMIT_W-1:0] rx_buffer_limit [NUM_CH];
	logic [COUNT_W-1:0] rx_spare_buffer_count [NUM_CH];

	logic [FLAG_W-1:0]  rx_raw;
	logic [FLAG_W-1:0]  rx_masked;
	logic [DMA_W-1:0]   dma_raw;
	logic [DMA_W-1:0]   dma_masked;
	logic [EVT_W-1:0]   evt_src;
	logic [EVT_W-1:0]   evt_rise;
	logic [DATA_W-1:0]  rd_data;
	logic               wr_stb;
	logic [DATA_W-1:0]  wr_data;

	// Status views
	assign rx_raw[FRAME_LSB +: NUM_CH]  = rx_frame_done_flag_r;
	assign rx_raw[THRESH_LSB +: NUM_CH] = rx_low_buffer_flag;
	// Enables are indexed exactly like the status bits
	assign rx_masked = rx_raw & rx_enable_r;
	assign dma_raw[HOST_BIT] = host_fault_flag_r;
	assign dma_raw[STAT_BIT] = counter_half_flag_r;
	assign dma_masked = dma_raw & dma_enable_r;

	assign o_rx_irq  = |rx_masked;
	assign o_dma_irq = |dma_masked;
	assign o_irq     = |(evt_status_r & evt_mask_r);

	// Address decode
	wire [2:0] bank_idx  = drx_bank_index(i_paddr);
	wire       hit_limit = drx_in_bank(i_paddr, OFS_LIMIT_BASE);
	wire       hit_count = drx_in_bank(i_paddr, OFS_COUNT_BASE);
	wire       hit_rx_raw  = (i_paddr == OFS_RX_RAW);
	wire       hit_rx_msk  = (i_paddr == OFS_RX_MASKED);
	wire       hit_rx_set  = (i_paddr == OFS_RX_SET);
	wire       hit_rx_clr  = (i_paddr == OFS_RX_CLEAR);
	wire       hit_dma_raw = (i_paddr == OFS_DMA_RAW);
	wire       hit_dma_msk = (i_paddr == OFS_DMA_MASKED);
	wire       hit_dma_en  = (i_paddr == OFS_DMA_ENABLE);
	wire       hit_evt_st  = (i_paddr == OFS_EVT_STATUS);
	wire       hit_evt_msk = (i_paddr == OFS_EVT_MASK);
	wire       addr_ok = hit_rx_raw | hit_rx_msk | hit_rx_set | hit_rx_clr | hit_dma_raw | hit_dma_msk
		| hit_dma_en | hit_evt_st | hit_evt_msk | hit_limit | hit_count;

	// Upper bits of every register read back as zero
	assign rd_data =
		hit_rx_raw  ? {16'h0000, rx_raw} :
		hit_rx_msk  ? {16'h0000, rx_masked} :
		(hit_rx_set | hit_rx_clr) ? {16'h0000, rx_enable_r} :
		hit_dma_raw ? {30'h00000000, dma_raw} :
		hit_dma_msk ? {30'h00000000, dma_masked} :
		hit_dma_en  ? {30'h00000000, dma_enable_r} :
		hit_evt_st  ? {14'h0000, evt_status_r} :
		hit_evt_msk ? {14'h0000, evt_mask_r} :
		hit_limit   ? {24'h000000, rx_buffer_limit[bank_idx]} :
		hit_count   ? {16'h0000, rx_spare_buffer_count[bank_idx]} :
		32'h00000000;

	// Raw and masked addresses have no write path at all
	wire wr_rx_set  = wr_stb & hit_rx_set;
	wire wr_rx_clr  = wr_stb & hit_rx_clr;
	wire wr_dma_en  = wr_stb & hit_dma_en;
	wire wr_evt_st  = wr_stb & hit_evt_st;
	wire wr_evt_msk = wr_stb & hit_evt_msk;

	// Set and clear are separate addresses, so one write never does both
	assign rx_enable_nxt = wr_rx_set ? (rx_enable_r | wr_data[FLAG_W-1:0]) :
		wr_rx_clr ? (rx_enable_r & ~wr_data[FLAG_W-1:0]) :
		rx_enable_r;

	// Sticky event latch: a new edge wins over a clear in the same cycle
	assign evt_src        = {dma_raw, rx_raw};
	assign evt_rise       = evt_src & ~evt_prev_r;
	assign evt_status_nxt = (evt_status_r & ~(wr_evt_st ? wr_data[EVT_W-1:0] : RST_EVT)) | evt_rise;

	drx_apb_port u_apb (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_clk_en   (i_clk_en),
		.i_psel     (i_psel),
		.i_penable  (i_penable),
		.i_pwrite   (i_pwrite),
		.i_pwdata   (i_pwdata),
		.i_pstrb    (i_pstrb),
		.i_rd_data  (rd_data),
		.i_addr_ok  (addr_ok),
		.o_pready   (o_pready),
		.o_prdata   (o_prdata),
		.o_pslverr  (o_pslverr),
		.o_wr_stb   (wr_stb),
		.o_wr_data  (wr_data)
	);

	for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
		drx_chan_thresh u_thresh (
			.i_core_clk (i_core_clk),
			.i_rst      (i_rst),
			.i_clk_en   (i_clk_en),
			.i_limit_wr (wr_stb & hit_limit & (bank_idx == 3'(g))),
			.i_count_wr (wr_stb & hit_count & (bank_idx == 3'(g))),
			.i_wr_data  (wr_data),
			.i_used_vld (i_rx_used_vld[g]),
			.i_used_cnt (i_rx_used_cnt[g]),
			.o_limit    (rx_buffer_limit[g]),
			.o_count    (rx_spare_buffer_count[g]),
			.o_low_flag (rx_low_buffer_flag[g])
		);
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			rx_frame_done_flag_r <= '0;
			host_fault_flag_r    <= 1'b0;
			counter_half_flag_r  <= 1'b0;
		end else if (i_clk_en) begin
			rx_frame_done_flag_r <= i_rx_frame_done;
			host_fault_flag_r    <= i_host_fault;
			counter_half_flag_r  <= |i_stat_counter_top;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			rx_enable_r  <= RST_RX_ENABLE;
			dma_enable_r <= RST_DMA_EN;
			evt_mask_r   <= RST_EVT;
		end else if (i_clk_en) begin
			rx_enable_r <= rx_enable_nxt;
			if (wr_dma_en) begin
				dma_enable_r <= wr_data[DMA_W-1:0];
			end
			if (wr_evt_msk) begin
				evt_mask_r <= wr_data[EVT_W-1:0];
			end
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			evt_prev_r   <= RST_EVT;
			evt_status_r <= RST_EVT;
		end else if (i_clk_en) begin
			evt_prev_r   <= evt_src;
			evt_status_r <= evt_status_nxt;
		end
	end

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);

	sequence s_bus_write(logic [ADDR_W-1:0] ofs);
		o_pready && i_pwrite && i_paddr == ofs;
	endsequence

	sequence s_bus_read(logic [ADDR_W-1:0] ofs);
		o_pready && !i_pwrite && i_paddr == ofs;
	endsequence

	// Expected low-buffer flags, one cycle ahead of the registered ones
	logic [NUM_CH-1:0] low_expect;
	always_comb begin
		for (int k = 0; k < NUM_CH; k++) begin
			low_expect[k] = rx_spare_buffer_count[k] < COUNT_W'(rx_buffer_limit[k]);
		end
	end

	chk_rx_raw_layout: assert property (
		i_clk_en |=> rx_raw[7:0] == $past(i_rx_frame_done))
		else $error("frame-done raw bits do not follow their channels");

	chk_thresh_layout: assert property (
		i_clk_en |=> rx_raw[THRESH_LSB +: NUM_CH] == $past(low_expect))
		else $error("low-buffer raw bits misplaced");

	chk_masked_view: assert property (
		s_bus_read(OFS_RX_MASKED) |-> o_prdata == {16'h0000, $past(rx_masked)})
		else $error("masked view read back wrong");

	chk_set_write: assert property (
		s_bus_write(OFS_RX_SET) |=> rx_enable_r == ($past(rx_enable_r) | $past(wr_data[15:0])))
		else $error("enable-set write did not turn on exactly the written bits");

	chk_set_readback: assert property (
		(o_pready && !i_pwrite && i_paddr == OFS_RX_SET) |-> o_prdata == {16'h0000, rx_enable_r})
		else $error("enable-set read does not show enables");

	chk_clear_write: assert property (
		s_bus_write(OFS_RX_CLEAR) |=> rx_enable_r == ($past(rx_enable_r) & ~$past(wr_data[15:0])))
		else $error("enable-clear write did not turn off exactly the written bits");

	chk_dma_raw_bits: assert property (
		i_clk_en |=> dma_raw == {$past(i_host_fault), |$past(i_stat_counter_top)})
		else $error("DMA raw bits do not follow host fault and statistics");

	chk_status_readonly: assert property (
		(s_bus_write(OFS_RX_RAW) or s_bus_write(OFS_DMA_RAW)) |=> $stable(rx_enable_r) && $stable(dma_enable_r))
		else $error("write to a status register changed state");

	chk_stat_flag: assert property (
		(i_clk_en && |i_stat_counter_top) |=> counter_half_flag_r)
		else $error("statistics flag missed a counter at half range");

	chk_irq_lines: assert property (
		o_rx_irq == |(rx_raw & rx_enable_r) && o_dma_irq == |(dma_raw & dma_enable_r))
		else $error("interrupt outputs disagree with masked flags");

	chk_sticky_set_wins: assert property (
		(i_clk_en && evt_rise[0]) |=> evt_status_r[0])
		else $error("new event lost against a clear");

	// Read data is latched in the setup cycle, so reads compare against that cycle
	chk_raw_read: assert property (
		s_bus_read(OFS_RX_RAW) |-> o_prdata == {16'h0000, $past(rx_raw)})
		else $error("raw status read back wrong");

	chk_dma_raw_read: assert property (
		s_bus_read(OFS_DMA_RAW) |-> o_prdata == {30'h0, $past(dma_raw)})
		else $error("DMA raw status read back wrong");

	chk_dma_masked_read: assert property (
		s_bus_read(OFS_DMA_MASKED) |-> o_prdata == {30'h0, $past(dma_masked)})
		else $error("DMA masked status read back wrong");

	chk_count_readback: assert property (
		s_bus_read(OFS_COUNT_BASE + 8'h08) |-> o_prdata == {16'h0000, $past(rx_spare_buffer_count[2])})
		else $error("spare buffer count read back wrong");

	chk_dma_enable_write: assert property (
		s_bus_write(OFS_DMA_ENABLE) |=> dma_enable_r == $past(wr_data[1:0]))
		else $error("DMA enable write not taken");

	chk_evt_mask_write: assert property (
		s_bus_write(OFS_EVT_MASK) |=> evt_mask_r == $past(wr_data[EVT_W-1:0]))
		else $error("event mask write not taken");

	// A clear in the same cycle as a new edge keeps the new edge
	chk_evt_clear: assert property (
		s_bus_write(OFS_EVT_STATUS) |=> (evt_status_r & $past(wr_data[EVT_W-1:0]) & ~$past(evt_rise)) == RST_EVT)
		else $error("event status bit survived a clear");

	chk_enable_layout: assert property (
		(rx_low_buffer_flag[2] && rx_enable_r[THRESH_LSB + 2]) |-> rx_masked[THRESH_LSB + 2] && o_rx_irq)
		else $error("threshold enable does not gate its own channel");

	// Unmapped addresses still complete, but with an error and no side effect
	chk_pslverr_map: assert property (
		o_pready |-> o_pslverr == !addr_ok)
		else $error("error response disagrees with the address map");

	chk_refused_write: assert property (
		(o_pready && i_pwrite && !addr_ok) |=> $stable(rx_enable_r) && $stable(dma_enable_r) && $stable(evt_mask_r))
		else $error("unmapped write changed an enable or mask");

	// Clock enable low must hold the enables, the event status and the frame-done flags
	chk_enable_freeze: assert property (
		!i_clk_en |=> $stable(rx_enable_r) && $stable(evt_status_r) && $stable(rx_frame_done_flag_r))
		else $error("state moved while the clock enable was low");

	// Checked across the reset edge itself, so the default disable is switched off here
	chk_reset_clears: assert property (
		disable iff (1'b0) $fell(i_rst) |-> rx_enable_r == RST_RX_ENABLE && dma_enable_r == RST_DMA_EN)
		else $error("enables not cleared by reset");

endmodule : drx_irq_top

`default_nettype wire

//--- drx_evt_model.sv
// Behavioural receive DMA engine driving the event inputs of the block.
// Assumes the bench calls its tasks from the core clock domain only.
`default_nettype none

module drx_evt_model
	import drx_pkg::*;
(
	input  wire logic                                            i_core_clk,
	output logic [drx_pkg::NUM_CH-1:0]                           o_frame_done,
	output logic [drx_pkg::NUM_CH-1:0]                           o_used_vld,
	output logic [drx_pkg::NUM_CH-1:0][drx_pkg::USED_W-1:0]      o_used_cnt,
	output logic                                                 o_host_fault,
	output logic [drx_pkg::STAT_NUM-1:0]                         o_stat_top
);
	timeunit 1ns;
	timeprecision 1ps;
	import drx_pkg::*;

	initial begin
		o_frame_done = '0;
		o_used_vld   = '0;
		o_used_cnt   = {NUM_CH{8'h5a}};
		o_host_fault = 1'b0;
		o_stat_top   = '0;
	end

	task automatic lv(input logic [7:0] f, input logic h, input logic [3:0] s);
		@(posedge i_core_clk);
		o_frame_done <= f;
		o_host_fault <= h;
		o_stat_top   <= s;
	endtask

	task automatic used(input int ch, input logic [7:0] n);
		@(posedge i_core_clk);
		o_used_vld[ch] <= 1'b1;
		o_used_cnt[ch] <= n;
		@(posedge i_core_clk);
		o_used_vld[ch] <= 1'b0;
		// Stale count must not look valid after the pulse
		o_used_cnt[ch] <= ~n;
	endtask
endmodule // drx_evt_model

`default_nettype wire

//--- tb_dma_rx_interrupt_status_mask.sv
// Self-checking bench for the receive interrupt status and enable block.
// Assumes the design package and the event model are compiled first.
`default_nettype none
`define CHK(g, x) begin checked++; if ((g) !== (x)) begin n_errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (g), (x)); end end

module tb_dma_rx_interrupt_status_mask;
	timeunit 1ns;
	timeprecision 1ps;
	import drx_pkg::*;

	logic                    clk;
	logic                    rst;
	logic                    ce;
	logic                    psel;
	logic                    penable;
	logic                    pwrite;
	logic [ADDR_W-1:0]       paddr;
	logic [DATA_W-1:0]       pwdata;
	logic                    pready;
	logic [DATA_W-1:0]       prdata;
	logic                    pslverr;
	logic [NUM_CH-1:0]       fd;
	logic [NUM_CH-1:0]       uv;
	logic [NUM_CH-1:0][7:0]  uc;
	logic                    hf;
	logic [STAT_NUM-1:0]     st;
	logic                    rx_irq;
	logic                    dma_irq;
	logic                    irq;
	logic [DATA_W-1:0]       q;
	logic                    e;
	int                      n_errors;
	int                      checked;

	drx_evt_model m (.i_core_clk(clk), .o_frame_done(fd), .o_used_vld(uv),
		.o_used_cnt(uc), .o_host_fault(hf), .o_stat_top(st));

	drx_irq_top dut (.i_core_clk(clk), .i_rst(rst), .i_clk_en(ce), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.i_pstrb(4'hf), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
		.i_rx_frame_done(fd), .i_rx_used_vld(uv), .i_rx_used_cnt(uc), .i_host_fault(hf),
		.i_stat_counter_top(st), .o_rx_irq(rx_irq), .o_dma_irq(dma_irq), .o_irq(irq));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic print_verdict();
		$display("checked=%0d n_errors=%0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask

	// One APB transfer; idle cycle before setup keeps each signal to one driver per step
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		int k;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (k == 20) begin
			n_errors++;
			print_verdict();
		end
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a);
		apb(1'b0, a, '0);
	endtask

	task automatic t_reset();
		rd(OFS_RX_SET);
		`CHK(q, 32'h0)
		rd(OFS_RX_RAW);
		`CHK(q, 32'h0)
		`CHK(irq, 1'b0)
		$display("test reset done");
	endtask

	task automatic t_frame();
		m.lv(8'ha5, 1'b0, 4'h0);
		idle(2);
		rd(OFS_RX_RAW);
		`CHK(q, 32'h000000a5)
		rd(OFS_RX_MASKED);
		`CHK(q, 32'h0)
		$display("test frame done");
	endtask

	task automatic t_enable();
		wr(OFS_RX_SET, 32'h000000f0);
		rd(OFS_RX_SET);
		`CHK(q, 32'h000000f0)
		wr(OFS_RX_SET, 32'h00000f00);
		rd(OFS_RX_CLEAR);
		`CHK(q, 32'h00000ff0)
		wr(OFS_RX_CLEAR, 32'h00000030);
		rd(OFS_RX_SET);
		`CHK(q, 32'h00000fc0)
		rd(OFS_RX_MASKED);
		`CHK(q, 32'h00000080)
		`CHK(rx_irq, 1'b1)
		wr(OFS_RX_CLEAR, 32'h0000ffff);
		idle(1);
		`CHK(rx_irq, 1'b0)
		$display("test enable done");
	endtask

	task automatic t_low();
		wr(OFS_LIMIT_BASE + 8'h08, 32'h5);
		wr(OFS_COUNT_BASE + 8'h08, 32'h3);
		idle(2);
		rd(OFS_RX_RAW);
		`CHK(q, 32'h000004a5)
		wr(OFS_COUNT_BASE + 8'h08, 32'h2);
		idle(2);
		rd(OFS_RX_RAW);
		`CHK(q, 32'h000000a5)
		m.used(2, 8'h01);
		idle(2);
		rd(OFS_COUNT_BASE + 8'h08);
		`CHK(q, 32'h4)
		wr(OFS_RX_SET, 32'h00000400);
		idle(1);
		`CHK(rx_irq, 1'b1)
		rd(OFS_RX_MASKED);
		`CHK(q, 32'h00000400)
		wr(OFS_RX_CLEAR, 32'h0000ffff);
		$display("test low buffer done");
	endtask

	task automatic t_dma();
		m.lv(8'ha5, 1'b1, 4'h0);
		idle(2);
		rd(OFS_DMA_RAW);
		`CHK(q, 32'h2)
		m.lv(8'ha5, 1'b1, 4'h8);
		idle(2);
		wr(OFS_DMA_RAW, 32'hffffffff);
		wr(OFS_RX_RAW, 32'hffffffff);
		rd(OFS_DMA_RAW);
		`CHK(q, 32'h3)
		rd(OFS_RX_RAW);
		`CHK(q, 32'h000004a5)
		wr(OFS_DMA_ENABLE, 32'h1);
		rd(OFS_DMA_MASKED);
		`CHK(q, 32'h1)
		`CHK(dma_irq, 1'b1)
		wr(OFS_DMA_ENABLE, 32'h0);
		m.lv(8'ha5, 1'b0, 4'h0);
		$display("test dma done");
	endtask

	task automatic t_map_irq();
		wr(8'h30, 32'hffffffff);
		`CHK(e, 1'b1)
		rd(OFS_RX_SET);
		`CHK(q, 32'h0)
		wr(OFS_EVT_STATUS, 32'h0003ffff);
		rd(OFS_EVT_STATUS);
		`CHK(q, 32'h0)
		m.lv(8'ha7, 1'b0, 4'h0);
		idle(3);
		rd(OFS_EVT_STATUS);
		`CHK(q, 32'h2)
		`CHK(irq, 1'b0)
		wr(OFS_EVT_MASK, 32'h2);
		idle(1);
		`CHK(irq, 1'b1)
		wr(OFS_EVT_STATUS, 32'h2);
		idle(1);
		`CHK(irq, 1'b0)
		$display("test map and irq done");
	endtask

	// Edges seen only while the clock enable is low must leave no trace
	task automatic t_freeze();
		@(posedge clk);
		ce <= 1'b0;
		m.lv(8'ha5, 1'b0, 4'h0);
		m.lv(8'ha7, 1'b0, 4'h0);
		m.lv(8'ha5, 1'b0, 4'h0);
		@(posedge clk);
		ce <= 1'b1;
		idle(3);
		`CHK(irq, 1'b0)
		rd(OFS_RX_RAW);
		`CHK(q, 32'h000004a5)
		$display("test clock enable done");
	endtask

	initial begin
		n_errors = 0;
		checked  = 0;
		rst      = 1'b1;
		ce       = 1'b1;
		psel     = 1'b0;
		penable  = 1'b0;
		pwrite   = 1'b0;
		paddr    = '0;
		pwdata   = '0;
		idle(10);
		rst <= 1'b0;
		t_reset();
		t_frame();
		t_enable();
		t_low();
		t_dma();
		t_map_irq();
		t_freeze();
		print_verdict();
	end
endmodule // tb_dma_rx_interrupt_status_mask

`undef CHK
`default_nettype wire
